// file: pkg/gcn_map.vh
// Address map, field positions and reset values of the change-notify GPIO port
`ifndef GCN_MAP_VH
`define GCN_MAP_VH
// -------------------------------------------------------------------
// Address decode: haddr[9] merge block, haddr[8] port, [7:4] register, [3:2] op
// -------------------------------------------------------------------
`define GCN_PORT_BIT 8
`define GCN_MERGE_BIT_ADDR 9
`define GCN_REG_HI 7
`define GCN_REG_LO 4
`define GCN_OP_HI 3
`define GCN_OP_LO 2
// Register index inside one port block (byte offset = index * 16)
`define GCN_REG_ANSEL 4'h0
`define GCN_REG_DIR 4'h1
`define GCN_REG_PORT 4'h2
`define GCN_REG_LAT 4'h3
`define GCN_REG_ODC 4'h4
`define GCN_REG_CNCTL 4'h5
`define GCN_REG_CNEN0 4'h6
`define GCN_REG_CNSTAT 4'h7
`define GCN_REG_CNEN1 4'h8
// Alias operation codes
`define GCN_OP_BASE 2'h0
`define GCN_OP_CLR 2'h1
`define GCN_OP_SET 2'h2
`define GCN_OP_INV 2'h3
// -------------------------------------------------------------------
// Fields and reset values
// -------------------------------------------------------------------
`define GCN_CN_ON_BIT 15
`define GCN_CN_STYLE_BIT 11
`define GCN_CNCTL_MASK 32'h8800_8800
`define GCN_MERGE_FIELD 0
`define GCN_ANSEL_RST 32'hFFFF_FFFF
`define GCN_DIR_RST 32'hFFFF_FFFF
`define GCN_ZERO_RST 32'h0000_0000
`endif

// file: hw/gcn_sync.v
// Pin input synchronizer, three system clocks from pin to port value
`include "gcn_map.vh"
module gcn_sync (
  input wire hclk,
  input wire hresetn,
  input wire [31:0] pin_in,
  output reg [31:0] pin_sync
);

  reg [31:0] meta_r;
  reg [31:0] stage2_r;

  // Two-flop crossing then a third capture stage
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_r <= `GCN_ZERO_RST;
      stage2_r <= `GCN_ZERO_RST;
      pin_sync <= `GCN_ZERO_RST;
    end
    else
    begin
      meta_r <= pin_in;
      stage2_r <= meta_r;
      pin_sync <= stage2_r;
    end
  end

endmodule

// file: hw/gcn_port.v
// Two 16-bit GPIO ports with aliases, merging and change notification, AHB-Lite slave
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`include "gcn_map.vh"
module gcn_port (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output reg [31:0] hrdata,
  output wire hresp,
  input wire [31:0] pin_in,
  output wire [31:0] pin_out,
  output wire [31:0] pin_oe,
  output wire [31:0] analog_level,
  output wire [31:0] analog_sel,
  output wire [1:0] cn_irq
);

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  reg [31:0] ansel_r;
  reg [31:0] dir_r;
  reg [31:0] lat_r;
  reg [31:0] odc_r;
  reg [31:0] cnctl_r;
  reg [31:0] cnen0_r;
  reg [31:0] cnen1_r;
  reg [31:0] cnstat_r;
  reg [31:0] last_rd_r;
  reg [31:0] prev_r;
  reg merge_r;
  reg [9:2] ap_addr_r;
  reg wr_ph_r;
  reg rd_wait_r;
  wire [31:0] pin_sync;
  wire ap_valid;

  // Port-side input synchronizer
  gcn_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(pin_in),
    .pin_sync(pin_sync)
  );

  // -------------------------------------------------------------------
  // Bus address and data phases
  // -------------------------------------------------------------------
  assign ap_valid = hsel & htrans[1] & hready;
  assign hreadyout = ~rd_wait_r; // One wait state on reads only
  assign hresp = 1'b0;

  // Address phase capture and phase tracking
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_addr_r <= 8'h00;
      wr_ph_r <= 1'b0;
      rd_wait_r <= 1'b0;
    end
    else
    begin
      if (ap_valid)
      begin
        ap_addr_r <= haddr[9:2];
      end
      wr_ph_r <= ap_valid & hwrite;
      rd_wait_r <= ap_valid & ~hwrite;
    end
  end

  // Decoded fields of the data-phase address
  wire dp_merge = ap_addr_r[`GCN_MERGE_BIT_ADDR];
  wire dp_port = ap_addr_r[`GCN_PORT_BIT];
  wire [3:0] dp_reg = ap_addr_r[`GCN_REG_HI:`GCN_REG_LO];
  wire [1:0] dp_op = ap_addr_r[`GCN_OP_HI:`GCN_OP_LO];

  // Lanes touched by an access: port 1, port 0, or both when merged and port 0 is addressed
  wire [31:0] lane_mask = dp_port ? 32'hFFFF_0000 :
                          (merge_r ? 32'hFFFF_FFFF : 32'h0000_FFFF);
  // Bus word placed on the pin lanes
  wire [31:0] lane_wdata = dp_port ? {hwdata[15:0], 16'h0000} : hwdata;

  // Alias operation on the selected lanes
  function [31:0] alias_apply;
    input [31:0] old;
    input [1:0] op;
    input [31:0] wd;
    input [31:0] msk;
    begin
      case (op)
        `GCN_OP_CLR: alias_apply = old & ~(wd & msk);
        `GCN_OP_SET: alias_apply = old | (wd & msk);
        `GCN_OP_INV: alias_apply = old ^ (wd & msk);
        default: alias_apply = (old & ~msk) | (wd & msk);
      endcase
    end
  endfunction

  // Write strobes per register
  wire wr_any = wr_ph_r & ~dp_merge;
  wire wr_ansel = wr_any & (dp_reg == `GCN_REG_ANSEL);
  wire wr_dir = wr_any & (dp_reg == `GCN_REG_DIR);
  wire wr_lat = wr_any & ((dp_reg == `GCN_REG_LAT) | (dp_reg == `GCN_REG_PORT));
  wire wr_odc = wr_any & (dp_reg == `GCN_REG_ODC);
  wire wr_cnctl = wr_any & (dp_reg == `GCN_REG_CNCTL);
  wire wr_cnen0 = wr_any & (dp_reg == `GCN_REG_CNEN0);
  wire wr_cnen1 = wr_any & (dp_reg == `GCN_REG_CNEN1);
  wire wr_cnstat = wr_any & (dp_reg == `GCN_REG_CNSTAT);
  wire wr_merge = wr_ph_r & dp_merge & (ap_addr_r[8:4] == 5'h00);
  wire rd_port = rd_wait_r & ~dp_merge & (dp_reg == `GCN_REG_PORT);

  // -------------------------------------------------------------------
  // Change-of-state detection
  // -------------------------------------------------------------------
  wire [31:0] on_v = {{16{cnctl_r[16 + `GCN_CN_ON_BIT]}}, {16{cnctl_r[`GCN_CN_ON_BIT]}}};
  wire [31:0] sty_v = {{16{cnctl_r[16 + `GCN_CN_STYLE_BIT]}},
                       {16{cnctl_r[`GCN_CN_STYLE_BIT]}}};
  wire [31:0] rise = pin_sync & ~prev_r;
  wire [31:0] fall = ~pin_sync & prev_r;
  // Edge style: (second, first) pair picks the transition
  wire [31:0] ev_edge = (~cnen1_r & cnen0_r & rise) |
                        (cnen1_r & ~cnen0_r & fall) |
                        (cnen1_r & cnen0_r & (rise | fall));
  // Mismatch style: second enable ignored
  wire [31:0] ev_mis = cnen0_r & (pin_sync ^ last_rd_r);
  wire [31:0] cn_event = on_v & ((sty_v & ev_edge) | (~sty_v & ev_mis));

  // Previous level for edge detection, free running
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_r <= `GCN_ZERO_RST;
    end
    else
    begin
      prev_r <= pin_sync;
    end
  end

  // Last-read state, taken when software reads the port value
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      last_rd_r <= `GCN_ZERO_RST;
    end
    else if (rd_port)
    begin
      last_rd_r <= (last_rd_r & ~lane_mask) | (pin_sync & lane_mask);
    end
  end

  // -------------------------------------------------------------------
  // Configuration registers
  // -------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ansel_r <= `GCN_ANSEL_RST;
      dir_r <= `GCN_DIR_RST;
      lat_r <= `GCN_ZERO_RST;
      odc_r <= `GCN_ZERO_RST;
      cnctl_r <= `GCN_ZERO_RST;
      cnen0_r <= `GCN_ZERO_RST;
      cnen1_r <= `GCN_ZERO_RST;
      merge_r <= 1'b0;
    end
    else
    begin
      if (wr_ansel)
      begin
        ansel_r <= alias_apply(ansel_r, dp_op, lane_wdata, lane_mask);
      end
      if (wr_dir)
      begin
        dir_r <= alias_apply(dir_r, dp_op, lane_wdata, lane_mask);
      end
      if (wr_lat)
      begin
        lat_r <= alias_apply(lat_r, dp_op, lane_wdata, lane_mask);
      end
      if (wr_odc)
      begin
        odc_r <= alias_apply(odc_r, dp_op, lane_wdata, lane_mask);
      end
      if (wr_cnctl)
      begin
        cnctl_r <= alias_apply(cnctl_r, dp_op, lane_wdata, lane_mask & `GCN_CNCTL_MASK);
      end
      if (wr_cnen0)
      begin
        cnen0_r <= alias_apply(cnen0_r, dp_op, lane_wdata, lane_mask);
      end
      if (wr_cnen1)
      begin
        cnen1_r <= alias_apply(cnen1_r, dp_op, lane_wdata, lane_mask);
      end
      if (wr_merge)
      begin
        case (dp_op)
          `GCN_OP_CLR: merge_r <= merge_r & ~hwdata[`GCN_MERGE_FIELD];
          `GCN_OP_SET: merge_r <= merge_r | hwdata[`GCN_MERGE_FIELD];
          `GCN_OP_INV: merge_r <= merge_r ^ hwdata[`GCN_MERGE_FIELD];
          default: merge_r <= hwdata[`GCN_MERGE_FIELD];
        endcase
      end
    end
  end

  // Sticky change flags; a new event wins over a software clear
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnstat_r <= `GCN_ZERO_RST;
    end
    else if (wr_cnstat)
    begin
      cnstat_r <= alias_apply(cnstat_r, dp_op, lane_wdata, lane_mask) | cn_event;
    end
    else
    begin
      cnstat_r <= cnstat_r | cn_event;
    end
  end

  // Interrupt request per port, held while any flag stands
  assign cn_irq = {|cnstat_r[31:16], |cnstat_r[15:0]};

  // -------------------------------------------------------------------
  // Read path
  // -------------------------------------------------------------------
  // Analog inputs read as low
  wire [31:0] port_val = pin_sync & ~ansel_r;

  // Base value of the addressed register on the pin lanes
  reg [31:0] rd_src;
  always @*
  begin
    rd_src = 32'h0000_0000;
    case (dp_reg)
      `GCN_REG_ANSEL: rd_src = ansel_r;
      `GCN_REG_DIR: rd_src = dir_r;
      `GCN_REG_PORT: rd_src = port_val;
      `GCN_REG_LAT: rd_src = lat_r;
      `GCN_REG_ODC: rd_src = odc_r;
      `GCN_REG_CNCTL: rd_src = cnctl_r;
      `GCN_REG_CNEN0: rd_src = cnen0_r;
      `GCN_REG_CNSTAT: rd_src = cnstat_r;
      `GCN_REG_CNEN1: rd_src = cnen1_r;
      default: rd_src = 32'h0000_0000;
    endcase
  end

  // Bus word of the read: lane shift, alias and unmapped read as zero
  reg [31:0] rd_word;
  always @*
  begin
    rd_word = 32'h0000_0000;
    if (dp_merge)
    begin
      rd_word = (ap_addr_r[8:2] == 7'h00) ? {31'h0000_0000, merge_r} : 32'h0000_0000;
    end
    else if (dp_op != `GCN_OP_BASE)
    begin
      rd_word = 32'h0000_0000;
    end
    else if (dp_port)
    begin
      rd_word = {16'h0000, rd_src[31:16]};
    end
    else
    begin
      rd_word = rd_src & lane_mask;
    end
  end

  // Read data register, loaded in the wait cycle
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (rd_wait_r)
    begin
      hrdata <= rd_word;
    end
  end

  // -------------------------------------------------------------------
  // Pin drive
  // -------------------------------------------------------------------
  // Output when direction is zero; open drain drives only a low
  assign pin_oe = ~dir_r & (~odc_r | ~lat_r);
  assign pin_out = lat_r & ~odc_r;

  // Digital output level offered to analog peripherals
  assign analog_level = lat_r & ~dir_r & ansel_r;
  assign analog_sel = ansel_r;

endmodule

// file: verification/gcn_port_properties.sv
// Checker of bus timing, reset state and request hold for the GPIO port
module gcn_port_props (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic hready,
  input logic hreadyout,
  input logic [31:0] hrdata,
  input logic [31:0] pin_oe,
  input logic [31:0] pin_out,
  input logic [31:0] analog_level,
  input logic [31:0] analog_sel,
  input logic [1:0] cn_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rd_dp;
  logic wr_dp;
  // ----------------------------------------------------------------
  // Data phase trackers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rd_dp <= 1'h0;
      wr_dp <= 1'h0;
    end
    else if (hready)
    begin
      rd_dp <= hsel && htrans[1] && !hwrite;
      wr_dp <= hsel && htrans[1] && hwrite;
    end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_rd_wait;
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_go;
    hsel && htrans[1] && hready && hwrite |=> hreadyout;
  endproperty
  a_wr_go: assert property (p_wr_go) else $error("write stalled");
  property p_rdata;
    !$stable(hrdata) |-> $past(rd_dp);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved");
  property p_rst_oe;
    $rose(hresetn) |-> pin_oe == 32'h0000_0000;
  endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("pin driven after reset");
  property p_rst_an;
    $rose(hresetn) |-> analog_sel == 32'hFFFF_FFFF;
  endproperty
  a_rst_an: assert property (p_rst_an) else $error("analog select reset");
  property p_an_lvl;
    ((analog_level & ~analog_sel) == 32'h0000_0000) &&
      ((analog_level & pin_oe) == (pin_out & pin_oe & analog_sel));
  endproperty
  a_an_lvl: assert property (p_an_lvl) else $error("analog level leak");
  property p_irq0;
    $fell(cn_irq[0]) |-> $past(wr_dp);
  endproperty
  a_irq0: assert property (p_irq0) else $error("request 0 dropped");
  property p_irq1;
    $fell(cn_irq[1]) |-> $past(wr_dp);
  endproperty
  a_irq1: assert property (p_irq1) else $error("request 1 dropped");
endmodule
bind gcn_port gcn_port_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .pin_oe(pin_oe), .pin_out(pin_out), .analog_level(analog_level),
  .analog_sel(analog_sel), .cn_irq(cn_irq));

// file: verification/gcn_pins.sv
// Board model: a pad follows the port when driven, the board otherwise
module gcn_pins (
  input logic [31:0] pin_out,
  input logic [31:0] pin_oe,
  input logic [31:0] ext_val,
  output logic [31:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released pads, open-drain highs too, take the pull-up or board level
  assign pin_in = (pin_out & pin_oe) | (ext_val & ~pin_oe);
endmodule

// file: verification/gcn_testbench.sv
// Self-checking bench for the change-notify GPIO port
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] ext = 32'hFFFF_FFFF;
  logic [31:0] lat, dir, ansel, odc, r, v, a;
  wire hrdy, hresp;
  wire [31:0] hrdata, pin_in, pin_out, pin_oe, alev, asel;
  wire [1:0] cn_irq;
  int mismatches = 0;
  int n_tests = 0;
  int i;
  always #20 hclk = ~hclk;
  gcn_port dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(hrdy), .hrdata(hrdata), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .analog_level(alev), .analog_sel(asel), .cn_irq(cn_irq));
  gcn_pins pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext), .pin_in(pin_in));
  // ----------------------------------------------------------------
  // Verdict, comparison and bus tasks
  // ----------------------------------------------------------------
  task automatic summarize;
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: %h not %h", $time, g, e);
    end
  endtask
  task automatic step;
    @(negedge hclk);
    while (hrdy !== 1'h1) @(negedge hclk);
    r = hrdata;
    @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= ad;
    step();
    htrans <= 2'h0;
    hwdata <= d;
    step();
  endtask
  task automatic rd(input logic [31:0] ad, input logic [31:0] e);
    bus(1'h0, ad, 32'h0000_0000);
    chk(r, e);
  endtask
  // Model port value for board levels e
  function automatic logic [31:0] pv(input logic [31:0] e);
    logic [31:0] o;
    o = ~dir & (~odc | ~lat);
    return ((lat & o) | (e & ~o)) & ~ansel;
  endfunction
  // Pad drive and analog outputs against the model, mid-cycle
  task automatic pads_ok;
    @(negedge hclk);
    chk(pin_oe, ~dir & (~odc | ~lat));
    chk(pin_out & ~dir, lat & ~dir & ~odc);
    chk(alev, lat & ~dir & ansel);
    chk(asel, ansel);
    chk({31'h0, hresp}, 32'h0000_0000);
    @(posedge hclk);
  endtask
  // Watchdog
  initial
  begin
    #800000;
    mismatches++;
    summarize();
  end
  // Main sequence
  initial
  begin
    void'($urandom(32'h4942));
    lat = 32'h0000_0000;
    odc = 32'h0000_0000;
    dir = 32'hFFFF_FFFF;
    ansel = 32'hFFFF_FFFF;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    pads_ok();
    rd(32'h0000_0010, 32'h0000_FFFF);
    for (i = 0; i < 8; i++)
    begin
      v = $urandom;
      a = ((i < 4) ? 32'h0000_0030 : 32'h0000_0020) + 32'(4 * (i % 4));
      bus(1'h1, a, v);
      case (i % 4)
        0: lat = v;
        1: lat = lat & ~v;
        2: lat = lat | v;
        default: lat = lat ^ v;
      endcase
      lat = lat & 32'h0000_FFFF;
      rd(32'h0000_0030, lat);
      if (i % 4 != 0) rd(a, 32'h0000_0000);
    end
    dir = 32'hFFFF_FF0F;
    odc = 32'h0000_0030;
    ansel = 32'hFFFF_FF80;
    bus(1'h1, 32'h0000_0010, dir);
    bus(1'h1, 32'h0000_0040, odc);
    bus(1'h1, 32'h0000_0000, ansel);
    bus(1'h1, 32'h0000_0038, 32'h0000_0080);
    lat = lat | 32'h0000_0080;
    pads_ok();
    v = ext;
    ext <= $urandom;
    rd(32'h0000_0020, pv(v) & 32'h0000_FFFF);
    rd(32'h0000_0020, pv(ext) & 32'h0000_FFFF);
    bus(1'h1, 32'h0000_0200, 32'h0000_0001);
    lat = $urandom;
    ansel = 32'h0000_FF00;
    bus(1'h1, 32'h0000_0030, lat);
    bus(1'h1, 32'h0000_0000, ansel);
    rd(32'h0000_0130, lat >> 16);
    rd(32'h0000_0020, pv(ext));
    bus(1'h1, 32'h0000_0204, 32'h0000_0001);
    rd(32'h0000_0030, lat & 32'h0000_FFFF);
    ext[0] <= 1'h0;
    for (i = 0; i < 5; i++)
    begin
      v = (i == 4) ? 32'h0000_0003 : 32'(i);
      bus(1'h1, 32'h0000_0050, (i < 4) ? 32'h0000_8800 : 32'h0000_0800);
      bus(1'h1, 32'h0000_0060, v & 32'h0000_0001);
      bus(1'h1, 32'h0000_0080, v >> 1);
      bus(1'h1, 32'h0000_0074, 32'h0000_FFFF);
      ext[0] <= 1'h1;
      repeat (6) @(posedge hclk);
      chk({30'h0, cn_irq}, {31'h0, (i < 4) & v[0]});
      bus(1'h1, 32'h0000_0074, 32'h0000_FFFF);
      ext[0] <= 1'h0;
      repeat (6) @(posedge hclk);
      chk({30'h0, cn_irq}, {31'h0, (i < 4) & v[1]});
    end
    // Mismatch style: second enable alone ignored, first enable flags a change
    rd(32'h0000_0020, pv(ext) & 32'h0000_FFFF);
    bus(1'h1, 32'h0000_0050, 32'h0000_8000);
    bus(1'h1, 32'h0000_0060, 32'h0000_0000);
    bus(1'h1, 32'h0000_0080, 32'h0000_0001);
    bus(1'h1, 32'h0000_0074, 32'h0000_FFFF);
    ext[0] <= 1'h1;
    repeat (6) @(posedge hclk);
    chk({30'h0, cn_irq}, 32'h0000_0000);
    bus(1'h1, 32'h0000_0060, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    chk({30'h0, cn_irq}, 32'h0000_0001);
    rd(32'h0000_0020, pv(ext) & 32'h0000_FFFF);
    bus(1'h1, 32'h0000_0074, 32'h0000_FFFF);
    @(posedge hclk);
    chk({30'h0, cn_irq}, 32'h0000_0000);
    hresetn <= 1'h0;
    @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd(32'h0000_0000, 32'h0000_FFFF);
    summarize();
  end
endmodule
